// ===== bench/adc_front_model.sv
// Converter front end model returning bench-chosen channel results
`timescale 1ns/1ps
`default_nettype none
module adc_front_model (
    // Clock
    input  wire logic        SYS_CLK,
    // Measurement window from the block
    input  wire logic        ADC_BUSY,
    input  wire logic        ADC_CH,
    // Values chosen by the bench
    input  wire logic [10:0] int_val,
    input  wire logic [10:0] ext_val,
    input  wire logic        fault_in,
    // Results and window bookkeeping
    output logic      [10:0] ADC_DATA,
    output logic             ADC_FAULT,
    output int               n_ext,
    output logic      [7:0]  len_ext
);
    logic        busy_q = 1'b0;
    logic        ch_q   = 1'b0;
    logic [7:0]  cnt_q  = 8'h00;
    logic [10:0] last_q = 11'h000;

    initial n_ext = 0;
    initial len_ext = 8'h00;
    // Outside a window the result lines show no stale value
    assign ADC_DATA  = ADC_BUSY ? (ADC_CH ? ext_val : int_val) : ~last_q;
    assign ADC_FAULT = (ADC_BUSY && ADC_CH) ? fault_in : !fault_in;

    always @(posedge SYS_CLK) begin
        if (busy_q && ch_q && (!ADC_BUSY || !ADC_CH)) begin
            len_ext <= cnt_q;
            n_ext   <= n_ext + 1;
        end
        if (ADC_BUSY) last_q <= ADC_DATA;
        cnt_q  <= !ADC_BUSY ? 8'h00 :
                  (busy_q && ADC_CH == ch_q) ? cnt_q + 8'h01 : 8'h01;
        busy_q <= ADC_BUSY;
        ch_q   <= ADC_CH;
    end
endmodule : adc_front_model
`default_nettype wire

// ===== bench/temp_monitor_limit_alerts_properties.sv
// Concurrent checks on the ports of the temperature monitor block
`timescale 1ns/1ps
`default_nettype none
module temp_monitor_limit_alerts_properties
    import temp_monitor_pkg::*;
(
    // Clock and reset
    input wire logic       SYS_CLK,
    input wire logic       RST,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic       REG_WE,
    input wire logic       REG_RE,
    input wire logic [7:0] REG_RDATA,
    // Converter front end
    input wire logic       ADC_BUSY,
    input wire logic       ADC_CH,
    input wire logic [5:0] ADC_AVG_HALF,
    // Open-drain pins
    input wire logic       ALERT_N_O,
    input wire logic       ALERT_N_OE,
    input wire logic       THERM_N_O,
    input wire logic       THERM_N_OE
);
    logic [7:0] cfg_q;
    logic [3:0] rate_q;
    logic [5:0] half_exp;
    wire        standby  = cfg_q[CFG_STANDBY];
    wire        shot_wr  = REG_WE && (REG_ADDR == OFF_ONE_SHOT);
    wire        mask_int = cfg_q[CFG_MASK_ALL] && !cfg_q[CFG_COMP];

    // Shadow of the writes the factor and mode checks depend on
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            cfg_q  <= CONFIG_RST;
            rate_q <= RATE_RST;
        end else if (REG_WE && REG_ADDR == OFF_CONFIG) begin
            cfg_q  <= REG_WDATA;
        end else if (REG_WE && REG_ADDR == OFF_RATE) begin
            rate_q <= REG_WDATA[3:0];
        end
    end

    always_comb begin
        if (rate_q >= 4'ha) half_exp = 6'h01;
        else if (cfg_q[CFG_AVG_DIS]) half_exp = 6'h02;
        else if (rate_q <= 4'h5) half_exp = 6'h20;
        else half_exp = 6'h20 >> (rate_q - 4'h5);
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    sequence s_masked;
        mask_int [*3];
    endsequence
    sequence s_shot_free;
        !shot_wr && !$past(shot_wr) && !$past(shot_wr, 2);
    endsequence

    property p_int_factor;
        ADC_BUSY && !ADC_CH |-> ADC_AVG_HALF == 6'h02;
    endproperty
    property p_ext_factor;
        ADC_BUSY && ADC_CH |-> ADC_AVG_HALF == half_exp;
    endproperty
    property p_pins_pull_only;
        ALERT_N_O == 1'b0 && THERM_N_O == 1'b0;
    endproperty
    property p_int_first;
        $rose(ADC_BUSY) |-> !ADC_CH;
    endproperty
    property p_standby_still;
        standby && !ADC_BUSY and s_shot_free |=> !ADC_BUSY;
    endproperty
    property p_shot_start;
        standby && !ADC_BUSY && shot_wr |-> ##[1:3] ADC_BUSY;
    endproperty
    property p_lo_zero;
        REG_RE && (REG_ADDR == OFF_INT_TEMP_LO || REG_ADDR == OFF_EXT_TEMP_LO)
            |=> REG_RDATA[4:0] == 5'h00;
    endproperty
    property p_therm_after_meas;
        $rose(THERM_N_OE) |-> $past(ADC_BUSY, 2) || $past(ADC_BUSY, 3);
    endproperty
    property p_therm_release_meas;
        $fell(THERM_N_OE) |-> $past(ADC_BUSY, 3) || $past(ADC_BUSY, 4);
    endproperty
    property p_mask_quiet;
        s_masked |-> !ALERT_N_OE;
    endproperty

    a_int_factor: assert property (p_int_factor)
        else $error("int factor not 1x");
    a_ext_factor: assert property (p_ext_factor)
        else $error("ext factor wrong");
    a_pins_pull_only: assert property (p_pins_pull_only)
        else $error("pin drives high");
    a_int_first: assert property (p_int_first)
        else $error("ext measured first");
    a_standby_still: assert property (p_standby_still)
        else $error("standby conversion");
    a_shot_start: assert property (p_shot_start)
        else $error("one-shot ignored");
    a_lo_zero: assert property (p_lo_zero)
        else $error("low byte bits set");
    a_therm_after_meas: assert property (p_therm_after_meas)
        else $error("crit rise unmeasured");
    a_therm_release_meas: assert property (p_therm_release_meas)
        else $error("crit fall unmeasured");
    a_mask_quiet: assert property (p_mask_quiet)
        else $error("masked warning low");
endmodule : temp_monitor_limit_alerts_properties
`default_nettype wire

// ===== bench/temp_monitor_limit_alerts_test.sv
// Register-driven test of the temperature monitor block
`timescale 1ns/1ps
`default_nettype none
module temp_monitor_limit_alerts_test
    import temp_monitor_pkg::*;
;
    logic             SYS_CLK, RST, REG_WE, REG_RE, fault_in;
    logic      [7:0]  REG_ADDR, REG_WDATA, d, e;
    logic      [10:0] int_val, ext_val;
    wire logic [7:0]  REG_RDATA, len_ext;
    wire logic [10:0] ADC_DATA;
    wire logic [5:0]  ADC_AVG_HALF;
    wire logic        ADC_BUSY, ADC_CH, ADC_FAULT;
    wire logic        ALERT_N_O, ALERT_N_OE, THERM_N_O, THERM_N_OE;
    int               n_ext, n_mismatch, num_checks;
    // Pull-ups resolve both open-drain lines
    wire logic [7:0]  alert_line = {7'h0, ALERT_N_OE ? ALERT_N_O : 1'b1};
    wire logic [7:0]  therm_line = {7'h0, THERM_N_OE ? THERM_N_O : 1'b1};

    temp_monitor_limit_alerts #(.MEAS_CYC(8), .SLOW_PERIOD_CYC(65536))
        i_temp_monitor_limit_alerts (.SYS_CLK(SYS_CLK), .RST(RST),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WE(REG_WE),
        .REG_RE(REG_RE), .REG_RDATA(REG_RDATA), .ADC_BUSY(ADC_BUSY),
        .ADC_CH(ADC_CH), .ADC_AVG_HALF(ADC_AVG_HALF), .ADC_DATA(ADC_DATA),
        .ADC_FAULT(ADC_FAULT), .ALERT_N_O(ALERT_N_O), .ALERT_N_OE(ALERT_N_OE),
        .THERM_N_O(THERM_N_O), .THERM_N_OE(THERM_N_OE));
    adc_front_model i_adc_front_model (.*);

    initial begin
        SYS_CLK = 1'b0;
        forever #4 SYS_CLK = ~SYS_CLK;
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        REG_ADDR <= a;
        REG_WDATA <= v;
        REG_WE <= 1'b1;
        @(posedge SYS_CLK);
        REG_WE <= 1'b0;
        @(posedge SYS_CLK);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        REG_ADDR <= a;
        REG_RE <= 1'b1;
        @(posedge SYS_CLK);
        REG_RE <= 1'b0;
        #1 d = REG_RDATA;
        @(posedge SYS_CLK);
    endtask : rd
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] m,
                           input logic [7:0] v);
        rd(a);
        check(d & m, v);
    endtask : chk_reg
    // Bounded waits: a run-out counts as a mismatch and ends the run
    task automatic wait_ext;
        int n0;
        n0 = n_ext;
        for (int k = 0; k < 70000 && n_ext == n0; k++) @(posedge SYS_CLK);
        if (n_ext == n0) begin
            n_mismatch++;
            print_verdict();
        end
        repeat (4) @(posedge SYS_CLK);
    endtask : wait_ext
    task automatic wait_idle;
        d = 8'h01;
        for (int k = 0; k < 400 && d[0] !== 1'b0; k++) rd(OFF_BUSY);
        if (d[0] !== 1'b0) begin
            n_mismatch++;
            print_verdict();
        end
    endtask : wait_idle

    initial begin
        {RST, REG_WE, REG_RE, fault_in} = 4'b1000;
        {REG_ADDR, REG_WDATA} = 16'h0000;
        int_val = 11'h100;
        ext_val = 11'h5a3;
        repeat (16) @(posedge SYS_CLK);
        RST <= 1'b0;
        @(posedge SYS_CLK);
        chk_reg(OFF_RATE, 8'hff, RATE_RST);
        chk_reg(OFF_CONFIG, 8'hff, 8'h00);
        wait_ext;
        wait_ext;
        check(len_ext, 8'd64);
        chk_reg(OFF_EXT_TEMP_HI, 8'hff, 8'hb4);
        chk_reg(OFF_EXT_TEMP_LO, 8'hff, 8'h60);
        wr(OFF_ONE_SHOT, 8'h01);
        chk_reg(OFF_BUSY, 8'h02, 8'h00);
        wr(OFF_CONFIG, 8'h40);
        wait_idle;
        ext_val <= 11'h125;
        repeat (2000) @(posedge SYS_CLK);
        chk_reg(OFF_EXT_TEMP_HI, 8'hff, 8'hb4);
        wr(OFF_ONE_SHOT, 8'h01);
        wait_ext;
        chk_reg(OFF_EXT_TEMP_HI, 8'hff, 8'h24);
        chk_reg(OFF_EXT_TEMP_LO, 8'hff, 8'ha0);
        // Each rate by one-shot keeps the run short at the slow rates
        for (int av = 0; av < 2; av++) begin
            for (int r = 0; r <= 10; r++) begin
                wait_idle;
                wr(OFF_CONFIG, av ? 8'h50 : 8'h40);
                wr(OFF_RATE, 8'(r));
                wr(OFF_ONE_SHOT, 8'h01);
                wait_ext;
                e = (r == 10) ? 8'd4 : av ? 8'd8 :
                    (r <= 5) ? 8'd128 : 8'd128 >> (r - 5);
                check(len_ext, e);
            end
        end
        wr(OFF_CONFIG, 8'h40);
        wr(OFF_LIM_BASE + 8'h05, 8'h30);
        wr(OFF_HYST, 8'h05);
        wr(OFF_CONSEC, 8'h10);
        ext_val <= {8'h30, 3'h0};
        wr(OFF_CONFIG, 8'h00);
        wait_ext;
        check(therm_line, 8'h01);
        ext_val <= {8'h20, 3'h0};
        wait_ext;
        ext_val <= {8'h30, 3'h0};
        wait_ext;
        check(therm_line, 8'h01);
        wait_ext;
        check(therm_line, 8'h00);
        chk_reg(OFF_STATUS, 8'h20, 8'h20);
        chk_reg(OFF_STATUS, 8'h20, 8'h20);
        ext_val <= {8'h2b, 3'h0};
        wait_ext;
        check(therm_line, 8'h00);
        ext_val <= {8'h2a, 3'h7};
        wait_ext;
        check(therm_line, 8'h01);
        chk_reg(OFF_STATUS, 8'h20, 8'h00);
        wr(OFF_CONSEC, 8'h00);
        wr(OFF_LIM_BASE + 8'h05, 8'h55);
        wr(OFF_LIM_BASE + 8'h03, 8'h40);
        wr(OFF_CH_MASK, 8'h02);
        ext_val <= {8'h40, 3'h0};
        wait_ext;
        check(alert_line, 8'h01);
        chk_reg(OFF_STATUS, 8'h02, 8'h02);
        wr(OFF_CH_MASK, 8'h00);
        wait_ext;
        check(alert_line, 8'h00);
        wr(OFF_CONFIG, 8'h80);
        wait_ext;
        check(alert_line, 8'h01);
        chk_reg(OFF_STATUS, 8'h02, 8'h02);
        wr(OFF_CONFIG, 8'h00);
        ext_val <= {8'h20, 3'h0};
        wait_ext;
        check(alert_line, 8'h00);
        // The clearing read still returns the bit it clears
        chk_reg(OFF_STATUS, 8'h02, 8'h02);
        repeat (3) @(posedge SYS_CLK);
        check(alert_line, 8'h01);
        wr(OFF_LIM_BASE + 8'h01, 8'h30);
        wait_ext;
        check(alert_line, 8'h00);
        chk_reg(OFF_STATUS, 8'h04, 8'h04);
        wr(OFF_LIM_BASE + 8'h01, 8'h00);
        fault_in <= 1'b1;
        wait_ext;
        chk_reg(OFF_STATUS, 8'h40, 8'h40);
        check(alert_line, 8'h00);
        fault_in <= 1'b0;
        wait_ext;
        rd(OFF_STATUS);
        wr(OFF_CONFIG, 8'ha0);
        ext_val <= {8'h40, 3'h0};
        wait_ext;
        check(alert_line, 8'h00);
        chk_reg(OFF_STATUS, 8'h02, 8'h02);
        chk_reg(OFF_STATUS, 8'h02, 8'h02);
        ext_val <= {8'h3b, 3'h0};
        wait_ext;
        check(alert_line, 8'h00);
        ext_val <= {8'h3a, 3'h7};
        wait_ext;
        check(alert_line, 8'h01);
        chk_reg(OFF_STATUS, 8'h02, 8'h00);
        wr(OFF_CH_MASK, 8'h02);
        ext_val <= {8'h40, 3'h0};
        wait_ext;
        check(alert_line, 8'h01);
        print_verdict();
    end
endmodule : temp_monitor_limit_alerts_test

bind temp_monitor_limit_alerts temp_monitor_limit_alerts_properties i_props (.*);
`default_nettype wire

// ===== rtl/temp_monitor_limit_alerts.sv
// Conversion scheduling, limit checking and alert pins of a temperature monitor
`timescale 1ns/1ps
`default_nettype none

module temp_monitor_limit_alerts
    import temp_monitor_pkg::*;
#(
    parameter int unsigned MEAS_CYC        = MEAS_CYC_DEF,
    parameter int unsigned SLOW_PERIOD_CYC = SLOW_PERIOD_CYC_DEF
) (
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    // Register port
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_WE,
    input  wire logic        REG_RE,
    output logic      [7:0]  REG_RDATA,
    // Converter front end
    output logic             ADC_BUSY,
    output logic             ADC_CH,
    output logic      [5:0]  ADC_AVG_HALF,
    input  wire logic [10:0] ADC_DATA,
    input  wire logic        ADC_FAULT,
    // Open-drain pins
    output logic             ALERT_N_O,
    output logic             ALERT_N_OE,
    output logic             THERM_N_O,
    output logic             THERM_N_OE
);

    initial begin
        if (MEAS_CYC < 4 || SLOW_PERIOD_CYC < 2048 ||
            64'(MEAS_CYC) * 64'd16 > 64'hffff_ffff) begin
            $error("bad timing parameters");
        end
    end

    typedef enum logic [1:0] {S_IDLE, S_MEAS, S_WAIT} conv_state_e;

    // Averaging factor in half units for a rate code
    function automatic logic [5:0] avg_half(input logic [3:0] rate,
                                            input logic       dis);
        if (rate >= RATE_MAX)
            avg_half = 6'h01;
        else if (dis)
            avg_half = 6'h02;
        else if (rate <= 4'h5)
            avg_half = 6'h20;
        else
            avg_half = 6'(6'h20 >> (rate - 4'h5));
    endfunction : avg_half

    // True when temperature sits below limit minus hysteresis
    function automatic logic below_hyst(input logic [10:0] t,
                                        input logic [7:0]  lim,
                                        input logic [7:0]  hyst);
        logic [8:0] thr;
        thr = {1'b0, lim} - {1'b0, hyst};
        below_hyst = !thr[8] && (t < {thr[7:0], 3'b000});
    endfunction : below_hyst

    // Register storage
    logic [7:0]  config_q;
    logic [3:0]  rate_q;
    logic [7:0]  hyst_q;
    logic [1:0]  ch_mask_q;
    logic [2:0]  cons_alert_q;
    logic [2:0]  cons_therm_q;
    logic [7:0]  high_q [NCH];
    logic [7:0]  low_q  [NCH];
    logic [7:0]  crit_q [NCH];
    logic [10:0] temp_q [NCH];
    logic [7:0]  status_q;
    logic [7:0]  rdata_q;

    // Conversion sequencer
    conv_state_e state_q;
    logic        ch_q;
    logic        shot_q;
    logic [31:0] meas_cnt_q;
    logic [31:0] per_cnt_q;
    logic        rel_q;

    // Per-channel limit tracking
    logic [2:0]  acnt_q [NCH];
    logic [2:0]  tcnt_q [NCH];
    logic [1:0]  live_hi_q;
    logic [1:0]  live_lo_q;
    logic        live_fault_q;
    logic        comp_q;
    logic        therm_q;
    logic        alert_q;

    // Configuration decode
    wire mask_all = config_q[CFG_MASK_ALL];
    wire standby  = config_q[CFG_STANDBY];
    wire comp     = config_q[CFG_COMP];
    wire avg_dis  = config_q[CFG_AVG_DIS];

    // Write strobes
    wire wr_config = REG_WE && REG_ADDR == OFF_CONFIG;
    wire wr_rate   = REG_WE && REG_ADDR == OFF_RATE;
    wire wr_shot   = REG_WE && REG_ADDR == OFF_ONE_SHOT;
    wire wr_hyst   = REG_WE && REG_ADDR == OFF_HYST;
    wire wr_mask   = REG_WE && REG_ADDR == OFF_CH_MASK;
    wire wr_consec = REG_WE && REG_ADDR == OFF_CONSEC;
    wire rd_status = REG_RE && REG_ADDR == OFF_STATUS;

    // Timing of the current step
    wire [5:0]  ext_half   = avg_half(rate_q, avg_dis);
    wire [31:0] ext_len    = 32'((64'(MEAS_CYC) * 64'(ext_half)) >> 1);
    wire [3:0]  rate_clamp = (rate_q > RATE_MAX) ? RATE_MAX : rate_q;
    wire [31:0] period_len = SLOW_PERIOD_CYC >> rate_clamp;
    wire        meas_done  = state_q == S_MEAS && meas_cnt_q == 32'd0;
    wire        abort      = state_q == S_MEAS && standby && !shot_q;
    wire        eval       = meas_done && !abort;
    // One-shot only starts from standby while idle
    wire        shot_go    = wr_shot && standby && state_q == S_IDLE;
    wire        start_cyc  = (state_q == S_IDLE && !standby) || shot_go ||
                             (state_q == S_WAIT && !standby &&
                              per_cnt_q == 32'd0);
    wire        last_ch    = ch_q == 1'(CH_EXT);

    // Measurement evaluation for the channel just finished
    wire        fault_now = ADC_FAULT && ch_q == 1'(CH_EXT);
    wire [10:0] val       = fault_now ? 11'h000 : ADC_DATA;
    wire        is_hi     = !fault_now && val >= {high_q[ch_q], 3'b000};
    wire        is_lo     = !fault_now && val <  {low_q[ch_q], 3'b000};
    wire        is_crit   = !fault_now && val >= {crit_q[ch_q], 3'b000};
    // Comparator mode watches only the high limit
    wire        bad_alert = comp ? is_hi : (is_hi || is_lo || fault_now);
    wire        q_alert   = eval && bad_alert &&
                            acnt_q[ch_q] >= cons_alert_q;
    wire        q_therm   = eval && is_crit &&
                            tcnt_q[ch_q] >= cons_therm_q;

    // Release thresholds over all stored results
    logic [NCH-1:0] below_crit;
    logic [NCH-1:0] below_high;
    logic [NCH-1:0] hi_event;
    logic [NCH-1:0] lo_event;
    logic [NCH-1:0] crit_event;
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        assign below_crit[c] = below_hyst(temp_q[c], crit_q[c], hyst_q);
        assign below_high[c] = below_hyst(temp_q[c], high_q[c], hyst_q);
        assign hi_event[c]   = q_alert && is_hi && ch_q == 1'(c);
        assign lo_event[c]   = q_alert && is_lo && ch_q == 1'(c);
        assign crit_event[c] = q_therm && ch_q == 1'(c);
    end

    wire therm_rel = rel_q && therm_q && &below_crit;
    wire comp_rel  = rel_q && comp && &below_high;
    wire fault_ev  = q_alert && fault_now;

    // Status clears: reads only clear conditions no longer present
    wire [1:0] clr_hi   = comp ? {2{comp_rel}}
                               : {2{rd_status}} & ~live_hi_q;
    wire [1:0] clr_lo   = {2{rd_status}} & ~live_lo_q;
    wire       clr_flt  = rd_status && !live_fault_q;
    wire [1:0] clr_crit = {2{therm_rel}};

    // Set wins over a clear in the same cycle
    wire [7:0] status_d = {1'b0,
        (status_q[ST_FAULT] && !clr_flt) || fault_ev,
        (status_q[ST_CRIT+1:ST_CRIT] & ~clr_crit) | crit_event,
        (status_q[ST_LOW+1:ST_LOW] & ~clr_lo) | lo_event,
        (status_q[ST_HIGH+1:ST_HIGH] & ~clr_hi) | hi_event};

    // Pin decisions
    wire [1:0] unmask   = ~ch_mask_q;
    wire       int_src  = |(status_d[ST_HIGH+1:ST_HIGH] & unmask) ||
                          |(status_d[ST_LOW+1:ST_LOW] & unmask) ||
                          (status_d[ST_FAULT] && unmask[CH_EXT]);
    wire       comp_set = |(hi_event & unmask);
    wire       comp_d   = comp && (comp_set || (comp_q && !comp_rel));
    wire       alert_d  = comp ? comp_d
                               : (int_src && !mask_all);
    wire       therm_d  = (|crit_event) || (therm_q && !therm_rel);

    // Read mux
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        unique case (REG_ADDR)
            OFF_INT_TEMP_HI: rd_mux = temp_q[CH_INT][10:3];
            OFF_INT_TEMP_LO: rd_mux = {temp_q[CH_INT][2:0], 5'b00000};
            OFF_EXT_TEMP_HI: rd_mux = temp_q[CH_EXT][10:3];
            OFF_EXT_TEMP_LO: rd_mux = {temp_q[CH_EXT][2:0], 5'b00000};
            OFF_STATUS:      rd_mux = status_q;
            OFF_CONFIG:      rd_mux = config_q;
            OFF_RATE:        rd_mux = {4'h0, rate_q};
            OFF_HYST:        rd_mux = hyst_q;
            OFF_CH_MASK:     rd_mux = {6'h00, ch_mask_q};
            OFF_CONSEC:      rd_mux = {1'b0, cons_therm_q, 1'b0, cons_alert_q};
            OFF_BUSY:        rd_mux = {6'h00, shot_q, state_q != S_IDLE};
            OFF_LIM_BASE:    rd_mux = high_q[CH_INT];
            OFF_LIM_BASE + 8'h01: rd_mux = low_q[CH_INT];
            OFF_LIM_BASE + 8'h02: rd_mux = crit_q[CH_INT];
            OFF_LIM_BASE + 8'h03: rd_mux = high_q[CH_EXT];
            OFF_LIM_BASE + 8'h04: rd_mux = low_q[CH_EXT];
            OFF_LIM_BASE + 8'h05: rd_mux = crit_q[CH_EXT];
            default:         rd_mux = 8'h00;
        endcase
    end

    // Configuration registers
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            config_q     <= CONFIG_RST;
            rate_q       <= RATE_RST;
            hyst_q       <= HYST_RST;
            ch_mask_q    <= 2'b00;
            cons_alert_q <= 3'd0;
            cons_therm_q <= 3'd0;
        end else begin
            if (wr_config) config_q  <= REG_WDATA;
            if (wr_rate)   rate_q    <= REG_WDATA[3:0];
            if (wr_hyst)   hyst_q    <= REG_WDATA;
            if (wr_mask)   ch_mask_q <= REG_WDATA[1:0];
            if (wr_consec) begin
                cons_alert_q <= REG_WDATA[CONS_ALERT_LSB +: 3];
                cons_therm_q <= REG_WDATA[CONS_THERM_LSB +: 3];
            end
        end
    end

    // Limits per channel
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            for (int c = 0; c < NCH; c++) begin
                high_q[c] <= HIGH_RST;
                low_q[c]  <= LOW_RST;
                crit_q[c] <= CRIT_RST;
            end
        end else if (REG_WE) begin
            for (int c = 0; c < NCH; c++) begin
                if (REG_ADDR == OFF_LIM_BASE + 8'(3 * c))
                    high_q[c] <= REG_WDATA;
                if (REG_ADDR == OFF_LIM_BASE + 8'(3 * c + 1))
                    low_q[c]  <= REG_WDATA;
                if (REG_ADDR == OFF_LIM_BASE + 8'(3 * c + 2))
                    crit_q[c] <= REG_WDATA;
            end
        end
    end

    // Conversion sequencer
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            state_q    <= S_IDLE;
            ch_q       <= 1'b0;
            shot_q     <= 1'b0;
            meas_cnt_q <= 32'd0;
            per_cnt_q  <= 32'd0;
        end else begin
            if (per_cnt_q != 32'd0)
                per_cnt_q <= per_cnt_q - 32'd1;
            unique case (state_q)
                S_IDLE, S_WAIT: begin
                    if (start_cyc) begin
                        state_q    <= S_MEAS;
                        ch_q       <= 1'(CH_INT);
                        shot_q     <= shot_go;
                        meas_cnt_q <= MEAS_CYC - 32'd1;
                        per_cnt_q  <= period_len - 32'd1;
                    end else if (state_q == S_WAIT && standby) begin
                        state_q <= S_IDLE;
                    end
                end
                S_MEAS: begin
                    if (abort) begin
                        state_q <= S_IDLE;
                    end else if (!meas_done) begin
                        meas_cnt_q <= meas_cnt_q - 32'd1;
                    end else if (!last_ch) begin
                        ch_q       <= 1'(CH_EXT);
                        meas_cnt_q <= ext_len - 32'd1;
                    end else begin
                        // One-shot ends back in standby
                        state_q <= shot_q ? S_IDLE : S_WAIT;
                        shot_q  <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Results and consecutive counters
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            for (int c = 0; c < NCH; c++) begin
                temp_q[c] <= 11'h000;
                acnt_q[c] <= 3'd0;
                tcnt_q[c] <= 3'd0;
            end
            live_hi_q    <= 2'b00;
            live_lo_q    <= 2'b00;
            live_fault_q <= 1'b0;
            rel_q        <= 1'b0;
        end else begin
            rel_q <= eval;
            if (eval) begin
                temp_q[ch_q]    <= val;
                // Saturating counters; a good result starts the run over
                acnt_q[ch_q]    <= !bad_alert ? 3'd0 :
                                   (acnt_q[ch_q] == 3'd7) ? 3'd7 :
                                   acnt_q[ch_q] + 3'd1;
                tcnt_q[ch_q]    <= !is_crit ? 3'd0 :
                                   (tcnt_q[ch_q] == 3'd7) ? 3'd7 :
                                   tcnt_q[ch_q] + 3'd1;
                live_hi_q[ch_q] <= q_alert && is_hi;
                live_lo_q[ch_q] <= q_alert && is_lo;
                if (ch_q == 1'(CH_EXT))
                    live_fault_q <= q_alert && fault_now;
            end
        end
    end

    // Status, pins and read data
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            status_q <= 8'h00;
            comp_q   <= 1'b0;
            alert_q  <= 1'b0;
            therm_q  <= 1'b0;
            rdata_q  <= 8'h00;
        end else begin
            status_q <= status_d;
            comp_q   <= comp_d;
            alert_q  <= alert_d;
            therm_q  <= therm_d;
            if (REG_RE)
                rdata_q <= rd_mux;
        end
    end

    // Outputs
    assign REG_RDATA    = rdata_q;
    assign ADC_BUSY     = state_q == S_MEAS;
    assign ADC_CH       = ch_q;
    assign ADC_AVG_HALF = (ch_q == 1'(CH_EXT)) ? ext_half : 6'h02;
    assign ALERT_N_O    = 1'b0;
    assign ALERT_N_OE   = alert_q;
    assign THERM_N_O    = 1'b0;
    assign THERM_N_OE   = therm_q;

endmodule : temp_monitor_limit_alerts

`default_nettype wire

// ===== rtl/temp_monitor_pkg.sv
// Constants shared by the temperature monitor control logic
package temp_monitor_pkg;

    // Timing figures in their own units
    localparam int unsigned T_MEAS_US        = 21000;     // Nominal channel time
    localparam int unsigned T_SLOW_PERIOD_US = 16000000;  // Period at 1/16 per s
    localparam int unsigned CLK_HZ           = 125000000;
    localparam int unsigned MEAS_CYC_DEF     =
        32'(64'(T_MEAS_US) * 64'(CLK_HZ) / 64'd1000000);
    localparam int unsigned SLOW_PERIOD_CYC_DEF =
        32'(64'(T_SLOW_PERIOD_US) * 64'(CLK_HZ) / 64'd1000000);

    // Channels
    localparam int NCH    = 2;
    localparam int CH_INT = 0;
    localparam int CH_EXT = 1;

    // Register offsets
    localparam logic [7:0] OFF_INT_TEMP_HI = 8'h00;
    localparam logic [7:0] OFF_INT_TEMP_LO = 8'h01;
    localparam logic [7:0] OFF_EXT_TEMP_HI = 8'h02;
    localparam logic [7:0] OFF_EXT_TEMP_LO = 8'h03;
    localparam logic [7:0] OFF_STATUS      = 8'h04;
    localparam logic [7:0] OFF_CONFIG      = 8'h05;
    localparam logic [7:0] OFF_RATE        = 8'h06;
    localparam logic [7:0] OFF_ONE_SHOT    = 8'h07;
    localparam logic [7:0] OFF_LIM_BASE    = 8'h08;  // High, low, crit per ch
    localparam logic [7:0] OFF_HYST        = 8'h0e;
    localparam logic [7:0] OFF_CH_MASK     = 8'h0f;
    localparam logic [7:0] OFF_CONSEC      = 8'h10;
    localparam logic [7:0] OFF_BUSY        = 8'h11;

    // Config field positions
    localparam int CFG_AVG_DIS  = 4;
    localparam int CFG_COMP     = 5;
    localparam int CFG_STANDBY  = 6;
    localparam int CFG_MASK_ALL = 7;

    // Status field positions (bit index plus channel; the fault field is a single bit)
    localparam int ST_HIGH  = 0;
    localparam int ST_LOW   = 2;
    localparam int ST_CRIT  = 4;
    localparam int ST_FAULT = 6;

    // Consecutive count field positions
    localparam int CONS_ALERT_LSB = 0;
    localparam int CONS_THERM_LSB = 4;

    // Reset values and the top rate code
    localparam logic [7:0] CONFIG_RST = 8'h00;
    localparam logic [3:0] RATE_RST   = 4'h6;
    localparam logic [3:0] RATE_MAX   = 4'ha;
    localparam logic [7:0] HIGH_RST   = 8'h55;
    localparam logic [7:0] LOW_RST    = 8'h00;
    localparam logic [7:0] CRIT_RST   = 8'h55;
    localparam logic [7:0] HYST_RST   = 8'h0a;

endpackage : temp_monitor_pkg
